// *** design/fsp_top.sv ***
// Sector protection logic: mode lock word, guard bits, freeze bit, bank gating
`timescale 1ns/1ps
module fsp_top
    import fsp_pkg::*;
#(
    parameter int NUM_SECT        = 256,
    parameter int SW              = 8,
    parameter bit VG_POWERUP_PROT = 1'b0
) (
    // Clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_b_in,
    // Wishbone classic slave
    input  wire logic          wb_cyc_in,
    input  wire logic          wb_stb_in,
    input  wire logic          wb_we_in,
    input  wire logic [7:0]    wb_adr_in,
    input  wire logic [3:0]    wb_sel_in,
    input  wire logic [31:0]   wb_dat_in,
    output logic [31:0]        wb_dat_out,
    output logic               wb_ack_out,
    // Password unlock result from the password logic (one-cycle pulse)
    input  wire logic          pw_unlock_in,
    // Array access check: hold req until ack
    input  wire logic          arr_req_in,
    input  wire logic          arr_write_in,
    input  wire logic          arr_alter_in,
    input  wire logic [SW-1:0] arr_sector_in,
    output logic               arr_ack_out,
    output logic               arr_grant_out,
    output logic               arr_guard_read_out,
    output logic               arr_guard_data_out
);

    typedef struct packed {
        fsp_state_t       state;
        fsp_state_t       ret;
        fsp_op_t          op;
        logic [15:0]      lock_word;
        logic [NUM_SECT-1:0] vg;
        logic             freeze;
        logic             init;
        logic [SW-1:0]    op_sect;
        logic [SW-1:0]    query;
        logic [15:0]      data;
        logic             timeout;
        logic             abort;
        logic             refused;
        logic             ack;
        logic [31:0]      rdat;
        logic             arr_pend;
        logic             arr_ack;
        logic             arr_grant;
        logic             arr_gread;
        logic             arr_gdata;
    } fsp_top_st_t;

    fsp_top_st_t st_q;
    fsp_top_st_t st_d;

    // Side-effect strobes to the store and timer, set in the comb process, and the bits they return
    logic          mem_prog;
    logic          mem_erase;
    logic          tmr_start;
    logic [15:0]   tmr_len;
    logic          tmr_busy;
    logic          tmr_done;
    logic          pg_q_bit;
    logic          pg_a_bit;

    // Bank of a sector: the top bits of its number
    function automatic logic [FSP_BANK_W-1:0] bank_of(input logic [SW-1:0] s);
        bank_of = s[SW-1 -: FSP_BANK_W];
    endfunction

    // Protected when either guard bit reads 0
    function automatic logic is_prot(input logic pg, input logic vg);
        is_prot = !pg || !vg;
    endfunction

    logic pw_mode;
    assign pw_mode = !st_q.lock_word[FSP_LW_PW_BIT];

    fsp_guard_mem #(
        .DEPTH (NUM_SECT),
        .AW    (SW)
    ) u_mem (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .prog_in       (mem_prog),
        .prog_addr_in  (st_q.op_sect),
        .erase_all_in  (mem_erase),
        .rd_a_addr_in  (st_q.query),
        .rd_a_data_out (pg_q_bit),
        .rd_b_addr_in  (arr_sector_in),
        .rd_b_data_out (pg_a_bit)
    );

    fsp_op_timer #(
        .CW (16)
    ) u_tmr (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .start_in (tmr_start),
        .len_in   (tmr_len),
        .busy_out (tmr_busy),
        .done_out (tmr_done)
    );

    // Whole next-state: bus slave, command decode, operations, array gating
    always_comb begin
        logic          bus_go;
        logic          bus_wr;
        logic [3:0]    code;
        logic [SW-1:0] sect;
        logic [1:0]    req_lock;
        logic [FSP_BANK_W-1:0] abank;
        bus_go   = wb_cyc_in && wb_stb_in && !st_q.ack;
        bus_wr   = wb_cyc_in && wb_stb_in && st_q.ack;
        code     = wb_dat_in[FSP_CMD_CODE_LSB +: 4];
        sect     = wb_dat_in[FSP_CMD_SECT_LSB +: SW];
        req_lock = {st_q.data[FSP_LW_PW_BIT], st_q.data[FSP_LW_PERS_BIT]};
        abank    = bank_of(arr_sector_in);
        st_d      = st_q;
        st_d.ack  = bus_go;
        st_d.init = 1'b0;
        mem_prog  = 1'b0;
        mem_erase = 1'b0;
        tmr_start = 1'b0;
        tmr_len   = 16'(FSP_PG_PROG_CYC);

        // One cycle after reset the freeze bit takes its mode-dependent value
        if (st_q.init) begin
            st_d.freeze = !pw_mode;
        end else if (pw_mode && pw_unlock_in) begin
            st_d.freeze = 1'b1;
        end

        // Register reads, captured into a flop so data stands with ack
        if (wb_adr_in == FSP_OFF_LOCK) begin
            st_d.rdat = {16'h0000, st_q.lock_word};
        end else if (wb_adr_in == FSP_OFF_DATA) begin
            st_d.rdat = {16'h0000, st_q.data};
        end else if (wb_adr_in == FSP_OFF_STATUS) begin
            st_d.rdat = '0;
            st_d.rdat[FSP_ST_BUSY]    = st_q.state == FSP_S_BUSY;
            st_d.rdat[FSP_ST_TIMEOUT] = st_q.timeout;
            st_d.rdat[FSP_ST_ABORT]   = st_q.abort;
            st_d.rdat[FSP_ST_REFUSED] = st_q.refused;
            st_d.rdat[FSP_ST_FREEZE]  = st_q.freeze;
            st_d.rdat[FSP_ST_PWMODE]  = pw_mode;
            st_d.rdat[FSP_ST_LMODE]   = st_q.state == FSP_S_LOCK;
            st_d.rdat[FSP_ST_PGMODE]  = st_q.state == FSP_S_PG;
        end else if (wb_adr_in == FSP_OFF_QUERY) begin
            st_d.rdat = '0;
            st_d.rdat[FSP_Q_PG]   = pg_q_bit;
            st_d.rdat[FSP_Q_VG]   = st_q.vg[st_q.query];
            st_d.rdat[FSP_Q_PROT] = is_prot(pg_q_bit, st_q.vg[st_q.query]);
        end else begin
            st_d.rdat = '0;
        end

        // Register writes land on the edge the master sees ack, never before it
        // Flags are write-one-to-clear on the status word
        if (bus_wr && wb_we_in && wb_sel_in[0]) begin
            if (wb_adr_in == FSP_OFF_DATA) begin
                st_d.data = wb_dat_in[15:0];
            end else if (wb_adr_in == FSP_OFF_QUERY) begin
                st_d.query = wb_dat_in[SW-1:0];
            end else if (wb_adr_in == FSP_OFF_STATUS) begin
                if (wb_dat_in[FSP_ST_TIMEOUT]) st_d.timeout = 1'b0;
                if (wb_dat_in[FSP_ST_ABORT])   st_d.abort   = 1'b0;
                if (wb_dat_in[FSP_ST_REFUSED]) st_d.refused = 1'b0;
            end else if (wb_adr_in == FSP_OFF_CMD) begin
                case (st_q.state)
                    FSP_S_IDLE: begin
                        if (code == FSP_C_LOCK_ENTER) begin
                            st_d.state = FSP_S_LOCK;
                        end else if (code == FSP_C_PG_ENTER) begin
                            st_d.state   = FSP_S_PG;
                            st_d.op_sect = sect;
                        end else if (code == FSP_C_VG_SET) begin
                            st_d.vg[sect] = 1'b0;
                        end else if (code == FSP_C_VG_CLEAR) begin
                            st_d.vg[sect] = 1'b1;
                        end else if (code == FSP_C_FREEZE_SET) begin
                            st_d.freeze = 1'b0;
                        end else if (code != FSP_C_EXIT) begin
                            st_d.refused = 1'b1;
                        end
                    end
                    FSP_S_LOCK: begin
                        if (code == FSP_C_EXIT) begin
                            st_d.state = FSP_S_IDLE;
                        end else if (code == FSP_C_LOCK_PROG) begin
                            if (req_lock == 2'b00) begin
                                st_d.abort = 1'b1;
                            end else if (req_lock != 2'b11 &&
                                         st_q.lock_word[FSP_LW_PW_BIT] &&
                                         st_q.lock_word[FSP_LW_PERS_BIT]) begin
                                // Only zeros are programmed into one-time bits
                                st_d.lock_word[FSP_LW_PW_BIT]   = req_lock[1];
                                st_d.lock_word[FSP_LW_PERS_BIT] = req_lock[0];
                            end else if (req_lock != 2'b11) begin
                                st_d.refused = 1'b1;
                            end
                        end else begin
                            st_d.refused = 1'b1;
                        end
                    end
                    FSP_S_PG: begin
                        if (code == FSP_C_EXIT) begin
                            st_d.state = FSP_S_IDLE;
                        end else if (code == FSP_C_PG_PROG ||
                                     code == FSP_C_PG_ERASE) begin
                            st_d.state = FSP_S_BUSY;
                            st_d.ret   = FSP_S_PG;
                            tmr_start  = 1'b1;
                            if (code == FSP_C_PG_PROG) begin
                                st_d.op_sect = sect;
                            end
                            if (!st_q.freeze) begin
                                st_d.op = FSP_OP_STALL;
                                tmr_len = 16'(FSP_TIMEOUT_CYC);
                            end else if (code == FSP_C_PG_PROG) begin
                                st_d.op = FSP_OP_PROG;
                                tmr_len = 16'(FSP_PG_PROG_CYC);
                            end else begin
                                // Pre-program and verify are folded into the time
                                st_d.op = FSP_OP_ERASE;
                                tmr_len = 16'(FSP_PG_ERASE_CYC);
                            end
                        end else begin
                            st_d.refused = 1'b1;
                        end
                    end
                    FSP_S_BUSY: begin
                        st_d.refused = 1'b1;
                    end
                    default: begin
                        st_d.state = FSP_S_IDLE;
                    end
                endcase
            end
        end

        // Finish an internal operation; the store changes only at the end
        if (st_q.state == FSP_S_BUSY && tmr_done) begin
            st_d.state = st_q.ret;
            if (st_q.op == FSP_OP_PROG) begin
                mem_prog = 1'b1;
            end else if (st_q.op == FSP_OP_ERASE) begin
                mem_erase = 1'b1;
            end else begin
                st_d.timeout = 1'b1;
            end
        end

        // Array check: the store read for the sector lands one cycle later
        st_d.arr_ack   = 1'b0;
        st_d.arr_pend  = arr_req_in && !st_q.arr_pend && !st_q.arr_ack;
        if (st_q.arr_pend) begin
            st_d.arr_ack   = 1'b1;
            st_d.arr_gread = 1'b0;
            st_d.arr_gdata = pg_a_bit;
            case (st_q.state)
                FSP_S_LOCK: begin
                    st_d.arr_grant = !arr_write_in && abank != FSP_BANK0;
                end
                FSP_S_PG: begin
                    if (abank == bank_of(st_q.op_sect)) begin
                        st_d.arr_grant = !arr_write_in;
                        st_d.arr_gread = !arr_write_in;
                    end else begin
                        st_d.arr_grant = !arr_write_in;
                    end
                end
                FSP_S_BUSY: begin
                    st_d.arr_grant = !arr_write_in && abank != FSP_BANK0 &&
                                     abank != bank_of(st_q.op_sect);
                end
                default: begin
                    // Current bits decide each accepted alter op
                    st_d.arr_grant = !(arr_write_in && arr_alter_in &&
                                       is_prot(pg_a_bit,
                                               st_q.vg[arr_sector_in]));
                end
            endcase
        end
    end

    // Reset: persistent mode, freeze unlocked, volatile bits per option
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q           <= '0;
            st_q.state     <= FSP_S_IDLE;
            st_q.ret       <= FSP_S_IDLE;
            st_q.op        <= FSP_OP_PROG;
            st_q.lock_word <= FSP_LW_RESET;
            st_q.vg        <= VG_POWERUP_PROT ? '0 : '1;
            st_q.freeze    <= 1'b1;
            st_q.init      <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs; the accelerate pin level plays no part in the guard logic
    assign wb_ack_out         = st_q.ack;
    assign wb_dat_out         = st_q.rdat;
    assign arr_ack_out        = st_q.arr_ack;
    assign arr_grant_out      = st_q.arr_grant;
    assign arr_guard_read_out = st_q.arr_gread;
    assign arr_guard_data_out = st_q.arr_gdata;

endmodule

// *** design/fsp_pkg.sv ***
// Shared constants and types for the flash sector protection logic
package fsp_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] FSP_OFF_LOCK    = 8'h00;
    localparam logic [7:0] FSP_OFF_CMD     = 8'h04;
    localparam logic [7:0] FSP_OFF_DATA    = 8'h08;
    localparam logic [7:0] FSP_OFF_STATUS  = 8'h0C;
    localparam logic [7:0] FSP_OFF_QUERY   = 8'h10;

    // Mode lock word layout and reset value (erased one-time bits read 1)
    localparam int         FSP_LW_PERS_BIT = 1;
    localparam int         FSP_LW_PW_BIT   = 2;
    localparam logic [15:0] FSP_LW_RESET   = 16'hFFFF;

    // Command register fields
    localparam int         FSP_CMD_CODE_LSB = 0;
    localparam int         FSP_CMD_SECT_LSB = 8;

    // Command codes
    localparam logic [3:0] FSP_C_LOCK_ENTER = 4'h1;
    localparam logic [3:0] FSP_C_LOCK_PROG  = 4'h2;
    localparam logic [3:0] FSP_C_PG_ENTER   = 4'h3;
    localparam logic [3:0] FSP_C_PG_PROG    = 4'h4;
    localparam logic [3:0] FSP_C_PG_ERASE   = 4'h5;
    localparam logic [3:0] FSP_C_VG_SET     = 4'h6;
    localparam logic [3:0] FSP_C_VG_CLEAR   = 4'h7;
    localparam logic [3:0] FSP_C_FREEZE_SET = 4'h8;
    localparam logic [3:0] FSP_C_EXIT       = 4'hF;

    // Status register bit positions
    localparam int FSP_ST_BUSY    = 0;
    localparam int FSP_ST_TIMEOUT = 1;
    localparam int FSP_ST_ABORT   = 2;
    localparam int FSP_ST_REFUSED = 3;
    localparam int FSP_ST_FREEZE  = 4;
    localparam int FSP_ST_PWMODE  = 5;
    localparam int FSP_ST_LMODE   = 6;
    localparam int FSP_ST_PGMODE  = 7;

    // Query register read bits
    localparam int FSP_Q_PG   = 0;
    localparam int FSP_Q_VG   = 1;
    localparam int FSP_Q_PROT = 2;

    // Internal operation times
    localparam int FSP_CLK_MHZ       = 100;
    localparam int FSP_PG_PROG_NS    = 5000;
    localparam int FSP_PG_ERASE_NS   = 20000;
    localparam int FSP_TIMEOUT_NS    = 10000;
    localparam int FSP_PG_PROG_CYC   = FSP_PG_PROG_NS * FSP_CLK_MHZ / 1000;
    localparam int FSP_PG_ERASE_CYC  = FSP_PG_ERASE_NS * FSP_CLK_MHZ / 1000;
    localparam int FSP_TIMEOUT_CYC   = FSP_TIMEOUT_NS * FSP_CLK_MHZ / 1000;

    // Bank 0 index; the bank is the top four bits of the sector number
    localparam logic [3:0] FSP_BANK0 = 4'h0;
    localparam int         FSP_BANK_W = 4;

    // Top state machine
    typedef enum logic [3:0] {
        FSP_S_IDLE  = 4'b0001,
        FSP_S_LOCK  = 4'b0010,
        FSP_S_PG    = 4'b0100,
        FSP_S_BUSY  = 4'b1000
    } fsp_state_t;

    // Kind of internal operation in progress
    typedef enum logic [2:0] {
        FSP_OP_PROG  = 3'b001,
        FSP_OP_ERASE = 3'b010,
        FSP_OP_STALL = 3'b100
    } fsp_op_t;

endpackage

// *** design/fsp_guard_mem.sv ***
// Per-sector persistent guard bit store with registered read ports
`timescale 1ns/1ps
module fsp_guard_mem #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    // Clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_b_in,
    // Single-bit program port (writes 0) and bulk erase (all to 1)
    input  wire logic          prog_in,
    input  wire logic [AW-1:0] prog_addr_in,
    input  wire logic          erase_all_in,
    // Two read ports
    input  wire logic [AW-1:0] rd_a_addr_in,
    output logic               rd_a_data_out,
    input  wire logic [AW-1:0] rd_b_addr_in,
    output logic               rd_b_data_out
);

    typedef struct packed {
        logic [DEPTH-1:0] bits;
        logic             rd_a;
        logic             rd_b;
    } fsp_mem_st_t;

    fsp_mem_st_t st_q;
    fsp_mem_st_t st_d;

    // Erase wins over program; both never come together from the top
    always_comb begin
        st_d = st_q;
        if (erase_all_in) begin
            st_d.bits = '1;
        end else if (prog_in) begin
            st_d.bits[prog_addr_in] = 1'b0;
        end
        st_d.rd_a = st_q.bits[rd_a_addr_in];
        st_d.rd_b = st_q.bits[rd_b_addr_in];
    end

    // Reset stands for a factory-fresh part: all guard bits erased
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q <= '{bits: '1, rd_a: 1'b1, rd_b: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_a_data_out = st_q.rd_a;
    assign rd_b_data_out = st_q.rd_b;

endmodule

// *** design/fsp_op_timer.sv ***
// Down-counter that times internal program, erase and stall operations
`timescale 1ns/1ps
module fsp_op_timer #(
    parameter int CW = 16
) (
    // Clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_b_in,
    // Start with a length in cycles; done pulses once at the end
    input  wire logic          start_in,
    input  wire logic [CW-1:0] len_in,
    output logic               busy_out,
    output logic               done_out
);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          busy;
        logic          done;
    } fsp_tmr_st_t;

    fsp_tmr_st_t st_q;
    fsp_tmr_st_t st_d;

    // Count down; a start while busy is ignored
    always_comb begin
        st_d      = st_q;
        st_d.done = 1'b0;
        if (st_q.busy) begin
            if (st_q.cnt <= CW'(1)) begin
                st_d.busy = 1'b0;
                st_d.done = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt - CW'(1);
            end
        end else if (start_in) begin
            st_d.busy = 1'b1;
            st_d.cnt  = len_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy_out = st_q.busy;
    assign done_out = st_q.done;

endmodule

// *** dv/fsp_top_props.sv ***
// Port-level assertions for the sector protection logic
`timescale 1ns/1ps
module fsp_top_props
    import fsp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // Register bus
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [31:0] wb_dat_out,
    input  wire logic        wb_ack_out,
    // Array access check
    input  wire logic        arr_req_in,
    input  wire logic        arr_ack_out,
    input  wire logic        arr_grant_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // Bus answers one cycle after a fresh request, and only once
    a_ack_one_late: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("bus ack missing");
    a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out) else $error("bus ack held");
    a_ack_has_cause: assert property (wb_ack_out |-> $past(wb_stb_in) && wb_cyc_in)
        else $error("bus ack unasked");
    // Holes in the map read as zero
    a_hole_reads_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in > 8'h13
        |-> wb_dat_out == 32'h0) else $error("hole read nonzero");
    // Spare lock bits stay one and both modes are never fixed together
    a_lock_word_legal: assert property (
        wb_ack_out && !wb_we_in && wb_adr_in == FSP_OFF_LOCK |-> wb_dat_out[15:3] == 13'h1FFF
        && wb_dat_out[0] && wb_dat_out[2:1] != 2'b00) else $error("lock word illegal");
    // Every check is judged two cycles after it is taken
    a_check_two_late: assert property ($rose(arr_req_in) |-> ##2 arr_ack_out)
        else $error("check answer late");
    a_check_pulse: assert property (arr_ack_out |=> !arr_ack_out) else $error("check ack held");
    a_grant_holds: assert property (!arr_ack_out |-> $stable(arr_grant_out))
        else $error("grant moved");
endmodule

bind fsp_top fsp_top_props u_props (.*);

// *** dv/fsp_arr_host.sv ***
// Array access requester standing in for the flash controller
`timescale 1ns/1ps
module fsp_arr_host (
    // Clock, reset and bench side
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       go_in,
    input  wire logic [9:0] op_in,
    output logic            done_out,
    // Array check side: write, alter, sector
    input  wire logic       ack_in,
    output logic            req_out,
    output logic [9:0]      op_out
);
    // Hold the request until ack; released lines never keep their old value
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            req_out <= 1'b0;
            op_out <= 10'h000;
            done_out <= 1'b0;
        end else begin
            done_out <= req_out && ack_in;
            if (req_out && ack_in) begin
                req_out <= 1'b0;
                op_out <= ~op_out;
            end else if (go_in && !req_out && !done_out) begin
                req_out <= 1'b1; // Single requests, write and alter bits and sector sent with the op
                op_out <= op_in;
            end
        end
    end
endmodule

// *** dv/fsp_top_tb.sv ***
// Self-checking bench for the sector protection logic
`timescale 1ns/1ps
module fsp_top_tb
    import fsp_pkg::*;
;
    logic        clk_in, ack, req, a_ack, grant, gread, gdata, done;
    logic        rst_b_in = 1'b0, cs = 1'b0, we = 1'b0, go = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [9:0]  op = 10'h000, aop;
    logic [31:0] wdat = 32'h0, rdat, v;
    int          fail_count = 0, cmp_count = 0, n_cyc = 0;
    // Cyc and stb always move together, so one wire feeds both
    fsp_top DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cs), .wb_stb_in(cs),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .pw_unlock_in(1'b0), .arr_req_in(req), .arr_write_in(aop[9]),
        .arr_alter_in(aop[8]), .arr_sector_in(aop[7:0]), .arr_ack_out(a_ack),
        .arr_grant_out(grant), .arr_guard_read_out(gread), .arr_guard_data_out(gdata));
    fsp_arr_host u_host (.clk_in(clk_in), .rst_b_in(rst_b_in), .go_in(go), .op_in(op),
        .done_out(done), .ack_in(a_ack), .req_out(req), .op_out(aop));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Longest path is a few thousand cycles of timed operations
    always @(posedge clk_in) begin
        n_cyc <= n_cyc + 1;
        if (n_cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        cs <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_in);
        while (ack !== 1'b1) @(posedge clk_in);
        v = rdat;
        cs <= 1'b0;
    endtask
    task automatic cmd(input logic [3:0] c, input logic [7:0] s);
        wb(1'b1, FSP_OFF_CMD, {16'h0, s, 4'h0, c});
    endtask
    // Query store is registered, so wait two cycles before reading
    task automatic q(input logic [7:0] s, input logic [2:0] e);
        wb(1'b1, FSP_OFF_QUERY, {24'h0, s});
        repeat (2) @(posedge clk_in);
        wb(1'b0, FSP_OFF_QUERY, 32'h0);
        chk("query", {29'h0, v[2:0]}, {29'h0, e});
    endtask
    task automatic ar(input logic [9:0] o, input logic e);
        @(posedge clk_in);
        go <= 1'b1;
        op <= o;
        @(posedge clk_in);
        while (done !== 1'b1) @(posedge clk_in);
        go <= 1'b0;
        chk("grant", {31'h0, grant}, {31'h0, e});
    endtask
    task automatic idle();
        do wb(1'b0, FSP_OFF_STATUS, 32'h0);
        while (v[FSP_ST_BUSY] !== 1'b0);
    endtask
    task automatic rst();
        rst_b_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (2) @(posedge clk_in);
    endtask
    task automatic lk(input logic [15:0] d, input logic [15:0] e, input logic [1:0] f);
        wb(1'b1, FSP_OFF_STATUS, 32'h0000000E);
        wb(1'b1, FSP_OFF_DATA, {16'h0, d});
        cmd(FSP_C_LOCK_PROG, 8'h00);
        idle();
        chk("flags", {30'h0, v[FSP_ST_REFUSED], v[FSP_ST_ABORT]}, {30'h0, f});
        wb(1'b0, FSP_OFF_LOCK, 32'h0);
        chk("lock", {16'h0, v[15:0]}, {16'h0, e});
    endtask
    task automatic t_reset();
        wb(1'b0, FSP_OFF_LOCK, 32'h0);
        chk("lock", {16'h0, v[15:0]}, {16'h0, FSP_LW_RESET});
        q(8'h05, 3'h3);
        wb(1'b0, 8'h40, 32'h0);
        chk("hole", v, 32'h0);
    endtask
    task automatic t_vol();
        cmd(FSP_C_VG_SET, 8'h25);
        q(8'h25, 3'h5);
        ar(10'h325, 1'b0);
        cmd(FSP_C_VG_CLEAR, 8'h25);
        ar(10'h325, 1'b1);
    endtask
    // Program one guard while probing banks, then erase them all
    task automatic t_guard();
        cmd(FSP_C_PG_ENTER, 8'h31);
        ar(10'h252, 1'b0);
        cmd(FSP_C_PG_PROG, 8'h31);
        ar(10'h005, 1'b0);
        ar(10'h03A, 1'b0);
        ar(10'h072, 1'b1);
        idle();
        ar(10'h031, 1'b1);
        chk("guard", {30'h0, gread, gdata}, 32'h2);
        q(8'h32, 3'h3);
        cmd(FSP_C_PG_ERASE, 8'h00);
        idle();
        q(8'h31, 3'h3);
        cmd(FSP_C_EXIT, 8'h00);
        ar(10'h305, 1'b1);
    endtask
    // Guards are already settled here, so freezing is the host's last step
    task automatic t_freeze();
        cmd(FSP_C_FREEZE_SET, 8'h00);
        cmd(FSP_C_PG_ENTER, 8'h40);
        cmd(FSP_C_PG_PROG, 8'h40);
        idle();
        chk("frozen", {30'h0, v[FSP_ST_FREEZE], v[FSP_ST_TIMEOUT]}, 32'h1);
        cmd(FSP_C_EXIT, 8'h00);
        q(8'h40, 3'h3);
        rst();
        idle();
        chk("freeze", {31'h0, v[FSP_ST_FREEZE]}, 32'h1);
    endtask
    task automatic t_lock();
        cmd(FSP_C_LOCK_ENTER, 8'h00);
        ar(10'h003, 1'b0);
        ar(10'h023, 1'b1);
        ar(10'h223, 1'b0);
        lk(16'hFFF9, 16'hFFFF, 2'b01);
        lk(16'hFFFD, 16'hFFFD, 2'b00);
        // No password is ever set, so its mode bit is only tried once refused
        lk(16'hFFFB, 16'hFFFD, 2'b10);
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        rst();
        t_reset();
        t_vol();
        t_guard();
        t_freeze();
        t_lock();
        give_verdict();
    end
endmodule
